/* rtl/fba_adapter.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`default_nettype none
module fba_adapter import fba_pkg::*; #(
  parameter int          TICK_CYC   = WD_UNIT_CYC,
  parameter int          GAP_LIMIT  = GAP_CYC,
  parameter logic [15:0] ADAPTER_ID = ADAPTER_ID_DEF
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // fieldbus transceiver
  input  wire logic        bus_rx,
  output logic             bus_tx,
  output logic             bus_tx_en,
  // front panel
  input  wire logic [6:0]  addr_sw,
  output logic             bus_fault_indicator,
  // base_side_link
  input  wire logic        base_info_vld,
  input  wire logic [7:0]  base_size,
  input  wire logic [7:0]  base_ident,
  input  wire logic        base_io_err,
  input  wire logic [7:0]  base_inputs,
  output logic [7:0]       base_outputs,
  output logic [7:0]       base_params,
  // supply and interrupt
  input  wire logic        supply_ok,
  output logic             irq
);
  // ==========================================================
  // pin synchronisers
  logic [33:0] sy1_ff, sy2_ff;
  logic        sup_ok, b_vld, io_err;
  logic [6:0]  my_addr;
  logic [7:0]  b_size, b_ident, b_in;
  assign {sup_ok, b_vld, io_err, my_addr, b_size, b_ident, b_in} = sy2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end else begin
      sy1_ff <= {supply_ok, base_info_vld, base_io_err, addr_sw,
                 base_size, base_ident, base_inputs};
      sy2_ff <= sy1_ff;
    end
  end

  // ==========================================================
  // protocol state
  fba_state_e  state_ff, nxt_state;
  logic [1:0]  idx_ff, nxt_idx;
  logic [7:0]  buf_ff [0:3];
  logic [7:0]  nxt_buf [0:3];
  logic [7:0]  rep1_ff, nxt_rep1, rep2_ff, nxt_rep2;
  logic [7:0]  size_ff, nxt_size, ident_ff, nxt_ident;
  logic [7:0]  mid_ff, nxt_mid, wdt_ff, nxt_wdt, wdc_ff, nxt_wdc;
  logic [19:0] wdd_ff, nxt_wdd;
  logic [15:0] gap_ff, nxt_gap;
  logic        base_ok_ff, nxt_base_ok, cfg_ok_ff, nxt_cfg_ok;
  logic        prm_ok_ff, nxt_prm_ok, rd_done_ff, nxt_rd_done;
  logic        wd_exp_ff, nxt_wd_exp, cfg_fail_ff, nxt_cfg_fail;
  logic        diag_ff, nxt_diag, ioe_d_ff, nxt_ioe_d;
  logic        drive_ff, nxt_drive, txs_ff, nxt_txs, bf_ff, nxt_bf;
  logic [7:0]  txb_ff, nxt_txb, out_ff, nxt_out, par_ff, nxt_par;
  logic [EV_W-1:0] ev;
  logic        diag_set, diag_clr, reply;
  logic [7:0]  rx_byte, st_byte;
  logic        rx_vld, rx_err, tx_busy;
  logic [31:0] ctrl_ff;
  logic [7:0]  safe_ff;
  logic        link_en;
  assign link_en = ctrl_ff[CTRL_EN_BIT];
  assign st_byte = {diag_ff, 5'h00, prm_ok_ff, cfg_ok_ff};

  // rx only listens while no reply is under way
  fba_uart u_uart (
    .pclk     (pclk),
    .presetn  (presetn),
    .rx_pin   (bus_rx),
    .tx_line  (bus_tx),
    .rx_en    (state_ff == ST_RX),
    .rx_byte  (rx_byte),
    .rx_vld   (rx_vld),
    .rx_err   (rx_err),
    .tx_start (txs_ff),
    .tx_byte  (txb_ff),
    .tx_busy  (tx_busy)
  );

  always_comb begin
    nxt_state = state_ff; nxt_idx = idx_ff; nxt_buf = buf_ff;
    nxt_rep1 = rep1_ff; nxt_rep2 = rep2_ff;
    nxt_size = size_ff; nxt_ident = ident_ff; nxt_mid = mid_ff;
    nxt_wdt = wdt_ff; nxt_wdc = wdc_ff; nxt_wdd = wdd_ff; nxt_gap = gap_ff;
    nxt_base_ok = base_ok_ff; nxt_cfg_ok = cfg_ok_ff; nxt_prm_ok = prm_ok_ff;
    nxt_rd_done = rd_done_ff; nxt_wd_exp = wd_exp_ff; nxt_cfg_fail = cfg_fail_ff;
    nxt_ioe_d = io_err; nxt_drive = drive_ff; nxt_txs = 1'b0; nxt_txb = txb_ff;
    nxt_out = out_ff; nxt_par = par_ff;
    ev = '0; diag_clr = 1'b0; reply = 1'b0;
    if (prm_ok_ff && wdt_ff != 8'h00 && !wd_exp_ff) begin
      if (wdd_ff == 20'(TICK_CYC - 1)) begin
        nxt_wdd = 20'h00000;
        nxt_wdc = wdc_ff + 8'h01;
      end else begin
        nxt_wdd = wdd_ff + 20'h00001;
      end
      if (wdc_ff == wdt_ff) begin
        nxt_wd_exp = 1'b1;
        ev[EV_WD] = 1'b1;
      end
    end
    // rising base error is latched for diagnostics
    if (io_err && !ioe_d_ff) ev[EV_IOERR] = 1'b1;
    case (state_ff)
      ST_BOOT: begin
        // latch base size and identity first
        if (b_vld) begin
          nxt_size = b_size;
          nxt_ident = b_ident;
          nxt_base_ok = 1'b1;
          nxt_state = ST_RX;
          ev[EV_BOOT] = 1'b1;
        end
      end
      ST_RX: begin
        if (rx_err) begin
          nxt_idx = 2'h0;
          ev[EV_FRAME] = 1'b1;
        end else if (rx_vld) begin
          nxt_buf[idx_ff] = rx_byte;
          nxt_gap = 16'h0000;
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == LAST_IDX) nxt_state = ST_EXEC;
        end else if (idx_ff != 2'h0) begin
          // a stalled frame is dropped so the next one realigns
          if (gap_ff == 16'(GAP_LIMIT - 1)) begin
            nxt_idx = 2'h0;
            nxt_gap = 16'h0000;
            ev[EV_FRAME] = 1'b1;
          end else begin
            nxt_gap = gap_ff + 16'h0001;
          end
        end
      end
      ST_EXEC: begin
        nxt_state = ST_RX;
        // only our own switch address is served
        if (link_en && buf_ff[0] == {1'b0, my_addr}) begin
          reply = 1'b1;
          case (buf_ff[1])
            FN_CFG: begin
              // exact match of ident and size
              nxt_cfg_ok = (buf_ff[2] == ident_ff) && (buf_ff[3] == size_ff);
              nxt_cfg_fail = !nxt_cfg_ok;
              nxt_prm_ok = 1'b0;
              nxt_rd_done = 1'b0;
              ev[EV_CFG] = !nxt_cfg_ok;
              nxt_rep1 = ident_ff;
              nxt_rep2 = size_ff;
            end
            FN_PRM: begin
              if (cfg_ok_ff) begin
                nxt_prm_ok = 1'b1;
                nxt_mid = buf_ff[2];
                nxt_wdt = buf_ff[3];
                nxt_wdc = 8'h00;
                nxt_wdd = 20'h00000;
                nxt_wd_exp = 1'b0;
              end
              nxt_rep1 = 8'h00;
              nxt_rep2 = 8'h00;
            end
            FN_DXI: begin
              reply = prm_ok_ff;
              nxt_rd_done = prm_ok_ff;
              nxt_rep1 = b_in;
              nxt_rep2 = 8'h00;
              nxt_wdc = 8'h00;
              nxt_wdd = 20'h00000;
            end
            FN_DXO: begin
              // output write only after input read
              reply = prm_ok_ff && rd_done_ff;
              if (reply) begin
                nxt_out = buf_ff[2];
                nxt_par = buf_ff[3];
                nxt_rd_done = 1'b0;
                nxt_wd_exp = 1'b0;
                nxt_wdc = 8'h00;
                nxt_wdd = 20'h00000;
              end
              nxt_rep1 = 8'h00;
              nxt_rep2 = 8'h00;
            end
            FN_DIAG: begin
              nxt_rep1 = 8'h00;
              nxt_rep1[DG_IOERR_BIT] = io_err;
              nxt_rep1[DG_WD_BIT] = wd_exp_ff;
              nxt_rep1[DG_CFG_BIT] = cfg_fail_ff;
              nxt_rep2 = 8'h00;
              diag_clr = 1'b1;
            end
            FN_ID: begin
              nxt_rep1 = ADAPTER_ID[15:8];
              nxt_rep2 = ADAPTER_ID[7:0];
            end
            default: reply = 1'b0;
          endcase
          if (reply) begin
            nxt_state = ST_TX;
            nxt_drive = 1'b1;
            nxt_idx = 2'h0;
          end
        end
      end
      ST_TX: begin
        // driver held for the whole reply only
        if (!tx_busy && !txs_ff) begin
          if (idx_ff == LAST_IDX) begin
            nxt_state = ST_RX;
            nxt_drive = 1'b0;
            nxt_idx = 2'h0;
          end else begin
            nxt_txs = 1'b1;
            // status byte carries the diagnostic flag
            nxt_txb = (idx_ff == 2'h0) ? st_byte :
                      (idx_ff == 2'h1) ? rep1_ff : rep2_ff;
            nxt_idx = idx_ff + 2'h1;
          end
        end
      end
      default: nxt_state = ST_BOOT;
    endcase
    // shutdown value whenever not exchanging safely
    if (nxt_wd_exp || !nxt_prm_ok) nxt_out = safe_ff;
    // supply fault returns the link state to boot and forces the shutdown value; apb registers keep their values
    if (!sup_ok) begin
      nxt_state = ST_BOOT; nxt_idx = 2'h0; nxt_base_ok = 1'b0;
      nxt_cfg_ok = 1'b0; nxt_prm_ok = 1'b0; nxt_rd_done = 1'b0;
      nxt_wd_exp = 1'b0; nxt_drive = 1'b0; nxt_txs = 1'b0;
      nxt_out = safe_ff; nxt_par = 8'h00;
    end
    // a new event beats a same-cycle poll
    diag_set = ev[EV_WD] | ev[EV_IOERR] | ev[EV_CFG];
    nxt_diag = (diag_ff & !diag_clr) | diag_set;
    // fault while linked but not exchanging
    nxt_bf = link_en && (!nxt_prm_ok || nxt_wd_exp);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_BOOT; idx_ff <= 2'h0; buf_ff <= '{default: 8'h00};
      rep1_ff <= 8'h00; rep2_ff <= 8'h00; size_ff <= 8'h00; ident_ff <= 8'h00;
      mid_ff <= 8'h00; wdt_ff <= 8'h00; wdc_ff <= 8'h00; wdd_ff <= 20'h00000;
      gap_ff <= 16'h0000; base_ok_ff <= 1'b0; cfg_ok_ff <= 1'b0;
      prm_ok_ff <= 1'b0; rd_done_ff <= 1'b0; wd_exp_ff <= 1'b0;
      cfg_fail_ff <= 1'b0; diag_ff <= 1'b0; ioe_d_ff <= 1'b0;
      drive_ff <= 1'b0; txs_ff <= 1'b0; txb_ff <= 8'h00; bf_ff <= 1'b0;
      out_ff <= SAFE_RST; par_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state; idx_ff <= nxt_idx; buf_ff <= nxt_buf;
      rep1_ff <= nxt_rep1; rep2_ff <= nxt_rep2; size_ff <= nxt_size;
      ident_ff <= nxt_ident; mid_ff <= nxt_mid; wdt_ff <= nxt_wdt;
      wdc_ff <= nxt_wdc; wdd_ff <= nxt_wdd; gap_ff <= nxt_gap;
      base_ok_ff <= nxt_base_ok; cfg_ok_ff <= nxt_cfg_ok;
      prm_ok_ff <= nxt_prm_ok; rd_done_ff <= nxt_rd_done;
      wd_exp_ff <= nxt_wd_exp; cfg_fail_ff <= nxt_cfg_fail;
      diag_ff <= nxt_diag; ioe_d_ff <= nxt_ioe_d; drive_ff <= nxt_drive;
      txs_ff <= nxt_txs; txb_ff <= nxt_txb; bf_ff <= nxt_bf;
      out_ff <= nxt_out; par_ff <= nxt_par;
    end
  end

  assign bus_tx_en = drive_ff;
  assign bus_fault_indicator = bf_ff;
  assign base_outputs = out_ff;
  assign base_params = par_ff;

  // ==========================================================
  // apb registers and interrupt
  logic [31:0] prd_ff, nxt_prd, nxt_ctrl;
  logic        prdy_ff, nxt_prdy, perr_ff, nxt_perr, irq_ff, nxt_irq;
  logic [7:0]  nxt_safe;
  logic [EV_W-1:0] ist_ff, nxt_ist, ien_ff, nxt_ien, clr;
  logic        wr;

  always_comb begin
    nxt_prdy = psel && !penable;
    nxt_prd = 32'h0000_0000;
    nxt_perr = 1'b0;
    nxt_ctrl = ctrl_ff; nxt_safe = safe_ff; nxt_ien = ien_ff;
    clr = '0;
    wr = psel && penable && prdy_ff && pwrite;
    if (psel && !penable) begin
      if (paddr == REG_CTRL) nxt_prd = ctrl_ff;
      else if (paddr == REG_STATUS)
        nxt_prd = {26'h0, state_ff, wd_exp_ff, prm_ok_ff, cfg_ok_ff, base_ok_ff};
      else if (paddr == REG_INT_ST) nxt_prd = {27'h0, ist_ff};
      else if (paddr == REG_INT_CLR) nxt_prd = 32'h0000_0000;
      else if (paddr == REG_INT_EN) nxt_prd = {27'h0, ien_ff};
      else if (paddr == REG_SAFE) nxt_prd = {24'h0, safe_ff};
      else if (paddr == REG_ADP_ID) nxt_prd = {16'h0, ADAPTER_ID};
      else if (paddr == REG_BASE) nxt_prd = {16'h0, size_ff, ident_ff};
      else if (paddr == REG_MASTER) nxt_prd = {16'h0, wdt_ff, mid_ff};
      else nxt_perr = 1'b1;
    end
    if (wr) begin
      if (paddr == REG_CTRL) nxt_ctrl = {31'h0, pwdata[CTRL_EN_BIT]};
      else if (paddr == REG_INT_CLR) clr = pwdata[EV_W-1:0];
      else if (paddr == REG_INT_EN) nxt_ien = pwdata[EV_W-1:0];
      else if (paddr == REG_SAFE) nxt_safe = pwdata[7:0];
    end
    // event in the clearing cycle survives
    nxt_ist = (ist_ff & ~clr) | ev;
    nxt_irq = |(ist_ff & ien_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_ff <= 32'h0000_0000; prdy_ff <= 1'b0; perr_ff <= 1'b0;
      ctrl_ff <= CTRL_RST; safe_ff <= SAFE_RST;
      ist_ff <= '0; ien_ff <= '0; irq_ff <= 1'b0;
    end else begin
      prd_ff <= nxt_prd; prdy_ff <= nxt_prdy; perr_ff <= nxt_perr;
      ctrl_ff <= nxt_ctrl; safe_ff <= nxt_safe;
      ist_ff <= nxt_ist; ien_ff <= nxt_ien; irq_ff <= nxt_irq;
    end
  end

  assign prdata = prd_ff;
  assign pready = prdy_ff;
  assign pslverr = perr_ff;
  assign irq = irq_ff;
endmodule : fba_adapter
`default_nettype wire

/* common/fba_pkg.sv */
`default_nettype none
package fba_pkg;
  // ==========================================================
  // clocking and bit timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int BIT_RATE    = 93_750;
  localparam int BIT_CYC     = CLK_HZ / BIT_RATE;
  localparam int HALF_CYC    = BIT_CYC / 2;
  localparam int GAP_BITS    = 33;
  localparam int GAP_CYC     = GAP_BITS * BIT_CYC;
  localparam int WD_UNIT_MS  = 10;
  localparam int WD_UNIT_CYC = (CLK_HZ / 1000) * WD_UNIT_MS;
  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_INT_ST  = 8'h08;
  localparam logic [7:0] REG_INT_CLR = 8'h0c;
  localparam logic [7:0] REG_INT_EN  = 8'h10;
  localparam logic [7:0] REG_SAFE    = 8'h14;
  localparam logic [7:0] REG_ADP_ID  = 8'h18;
  localparam logic [7:0] REG_BASE    = 8'h1c;
  localparam logic [7:0] REG_MASTER  = 8'h20;
  // ==========================================================
  // fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [7:0]  SAFE_RST = 8'h00;
  localparam int EV_BOOT  = 0;
  localparam int EV_CFG   = 1;
  localparam int EV_WD    = 2;
  localparam int EV_IOERR = 3;
  localparam int EV_FRAME = 4;
  localparam int EV_W     = 5;
  localparam int ST_DIAG_BIT = 7;
  localparam int ST_PRM_BIT  = 1;
  localparam int ST_CFG_BIT  = 0;
  localparam int DG_IOERR_BIT = 0;
  localparam int DG_WD_BIT    = 1;
  localparam int DG_CFG_BIT   = 2;
  // arbitrary value, not a real registration
  localparam logic [15:0] ADAPTER_ID_DEF = 16'h0a5c;
  // ==========================================================
  // function codes
  localparam logic [7:0] FN_CFG  = 8'h01;
  localparam logic [7:0] FN_PRM  = 8'h02;
  localparam logic [7:0] FN_DXI  = 8'h03;
  localparam logic [7:0] FN_DXO  = 8'h04;
  localparam logic [7:0] FN_DIAG = 8'h05;
  localparam logic [7:0] FN_ID   = 8'h06;
  localparam logic [1:0] LAST_IDX = 2'h3;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RX   = 2'b01,
    ST_EXEC = 2'b10,
    ST_TX   = 2'b11
  } fba_state_e;
endpackage : fba_pkg
`default_nettype wire

/* rtl/fba_uart.sv */
`default_nettype none
module fba_uart import fba_pkg::*; (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // line
  input  wire logic       rx_pin,
  output logic            tx_line,
  // receive side
  input  wire logic       rx_en,
  output logic [7:0]      rx_byte,
  output logic            rx_vld,
  output logic            rx_err,
  // transmit side
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_byte,
  output logic            tx_busy
);
  logic        s1_ff, s2_ff;
  logic        rb_ff, nxt_rb;
  logic [11:0] rc_ff, nxt_rc;
  logic [3:0]  ri_ff, nxt_ri;
  logic [7:0]  rs_ff, nxt_rs;
  logic        rv_ff, nxt_rv, re_ff, nxt_re;
  logic        tb_ff, nxt_tb, tl_ff, nxt_tl;
  logic [11:0] tc_ff, nxt_tc;
  logic [3:0]  ti_ff, nxt_ti;
  logic [9:0]  ts_ff, nxt_ts;

  assign rx_byte = rs_ff;
  assign rx_vld  = rv_ff;
  assign rx_err  = re_ff;
  assign tx_line = tl_ff;
  assign tx_busy = tb_ff;

  // ==========================================================
  // 8n1 receive and transmit
  always_comb begin
    nxt_rb = rb_ff; nxt_rc = rc_ff; nxt_ri = ri_ff; nxt_rs = rs_ff;
    nxt_rv = 1'b0; nxt_re = 1'b0;
    nxt_tb = tb_ff; nxt_tc = tc_ff; nxt_ti = ti_ff; nxt_ts = ts_ff;
    nxt_tl = tl_ff;
    if (!rb_ff) begin
      if (rx_en && !s2_ff) begin
        nxt_rb = 1'b1;
        nxt_rc = 12'(HALF_CYC);
        nxt_ri = 4'h0;
      end
    end else if (rc_ff == 12'h000) begin
      nxt_rc = 12'(BIT_CYC - 1);
      if (ri_ff == 4'h0) begin
        // glitch shorter than half a bit is not a start
        if (s2_ff) nxt_rb = 1'b0;
        else nxt_ri = 4'h1;
      end else if (ri_ff < 4'h9) begin
        nxt_rs = {s2_ff, rs_ff[7:1]};
        nxt_ri = ri_ff + 4'h1;
      end else begin
        nxt_rb = 1'b0;
        nxt_rv = s2_ff;
        nxt_re = !s2_ff;
      end
    end else begin
      nxt_rc = rc_ff - 12'h001;
    end
    if (!tb_ff) begin
      nxt_tl = 1'b1;
      if (tx_start) begin
        nxt_tb = 1'b1;
        nxt_ts = {1'b1, tx_byte, 1'b0};
        nxt_ti = 4'h0;
        nxt_tc = 12'h000;
      end
    end else if (tc_ff == 12'h000) begin
      if (ti_ff == 4'ha) begin
        nxt_tb = 1'b0;
        nxt_tl = 1'b1;
      end else begin
        nxt_tl = ts_ff[0];
        nxt_ts = {1'b1, ts_ff[9:1]};
        nxt_ti = ti_ff + 4'h1;
        nxt_tc = 12'(BIT_CYC - 1);
      end
    end else begin
      nxt_tc = tc_ff - 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b1; s2_ff <= 1'b1;
      rb_ff <= 1'b0; rc_ff <= 12'h000; ri_ff <= 4'h0; rs_ff <= 8'h00;
      rv_ff <= 1'b0; re_ff <= 1'b0;
      tb_ff <= 1'b0; tc_ff <= 12'h000; ti_ff <= 4'h0; ts_ff <= 10'h3ff;
      tl_ff <= 1'b1;
    end else begin
      s1_ff <= rx_pin; s2_ff <= s1_ff;
      rb_ff <= nxt_rb; rc_ff <= nxt_rc; ri_ff <= nxt_ri; rs_ff <= nxt_rs;
      rv_ff <= nxt_rv; re_ff <= nxt_re;
      tb_ff <= nxt_tb; tc_ff <= nxt_tc; ti_ff <= nxt_ti; ts_ff <= nxt_ts;
      tl_ff <= nxt_tl;
    end
  end
endmodule : fba_uart
`default_nettype wire

/* testbench/fba_adapter_properties.sv */
`default_nettype none
module fba_adapter_properties import fba_pkg::*; (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and base
  input wire logic        bus_tx,
  input wire logic        bus_tx_en,
  input wire logic        base_info_vld,
  input wire logic        supply_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // boot tracking
  logic seen_ff;
  logic nxt_seen;
  // clears at once on a supply drop, so it is stricter than the synced design
  always_comb nxt_seen = supply_ok & (seen_ff | base_info_vld);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_ff <= 1'b0;
    else seen_ff <= nxt_seen;
  end
  // ==========================================
  // properties
  tx_idle_high_a: assert property (!bus_tx_en |-> bus_tx)
    else $error("line not idle while driver off");
  tx_start_high_a: assert property ($rose(bus_tx_en) |-> bus_tx)
    else $error("driver enabled on a low line");
  tx_stop_end_a: assert property ($fell(bus_tx_en) |-> $past(bus_tx, 2) && bus_tx)
    else $error("reply ended outside a stop bit");
  boot_silent_a: assert property (!seen_ff |-> !bus_tx_en)
    else $error("reply before base info");
  supply_quiet_a: assert property (!supply_ok [*4] |-> !bus_tx_en)
    else $error("reply during supply fault");
  apb_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_error_a: assert property (psel && !penable && paddr > 8'h20 |=> pslverr && pready)
    else $error("no error on unmapped access");
  rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
endmodule : fba_adapter_properties
`default_nettype wire

/* testbench/fba_master_model.sv */
`default_nettype none
module fba_master_model import fba_pkg::*; (
  // line
  input  wire logic pclk,
  input  wire logic bus_tx,
  input  wire logic bus_tx_en,
  output var logic  bus_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // master side of the link
  initial bus_rx = 1'b1;
  // frames sent whole, bytes back to back
  // parameter frame: addr, 02, master id, watchdog units, sent once
  // master data control time is left to the caller's frame pacing
  task automatic send_frame(input logic [31:0] f);
    logic [9:0] sh;
    for (int b = 3; b >= 0; b--) begin
      sh = {1'b1, f[b*8 +: 8], 1'b0};
      for (int i = 0; i < 10; i++) begin
        bus_rx <= sh[i];
        // line idles high after the last stop bit, so return early to catch the reply start
        repeat ((b == 0 && i == 9) ? HALF_CYC : BIT_CYC) @(posedge pclk);
      end
    end
  endtask : send_frame
  task automatic get_reply(output logic [23:0] r, output logic ok);
    int n;
    r = 24'h0;
    n = 0;
    while (bus_tx_en !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    for (int b = 2; b >= 0; b--) begin
      n = 0;
      while (bus_tx !== 1'b0 && n < 4 * BIT_CYC) begin
        @(posedge pclk);
        n++;
      end
      repeat (HALF_CYC) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        r[b*8+i] = bus_tx;
      end
      repeat (BIT_CYC) @(posedge pclk);
    end
    n = 0;
    // next frame only after the driver lets go
    while (bus_tx_en !== 1'b0 && n < 2 * BIT_CYC) begin
      @(posedge pclk);
      n++;
    end
    ok = (n < 2 * BIT_CYC);
  endtask : get_reply
endmodule : fba_master_model
`default_nettype wire

/* testbench/fba_adapter_test.sv */
`default_nettype none
module fba_adapter_test import fba_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ok;
  logic bus_rx, bus_tx, bus_tx_en, bus_fault_indicator;
  logic base_info_vld, base_io_err, supply_ok;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  paddr, base_size, base_ident, base_inputs, base_outputs, base_params, s;
  logic [6:0]  addr_sw;
  logic [23:0] r;
  int          mismatches, n_tests;
  // ==========================================
  // design and far side
  // adapter id value is arbitrary
  fba_adapter #(.TICK_CYC(50), .ADAPTER_ID(16'h1234)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_rx(bus_rx), .bus_tx(bus_tx),
    .bus_tx_en(bus_tx_en), .addr_sw(addr_sw), .bus_fault_indicator(bus_fault_indicator),
    .base_info_vld(base_info_vld), .base_size(base_size), .base_ident(base_ident),
    .base_io_err(base_io_err), .base_inputs(base_inputs), .base_outputs(base_outputs),
    .base_params(base_params), .supply_ok(supply_ok), .irq(irq));
  fba_master_model i_mst (.pclk(pclk), .bus_tx(bus_tx), .bus_tx_en(bus_tx_en), .bus_rx(bus_rx));
  always #5 pclk = ~pclk;
  // ==========================================
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    ok = pslverr;
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask : rchk
  // ==========================================
  // scenarios
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, base_info_vld, base_io_err} = '0;
    supply_ok = 1'b1;
    void'($urandom(32'h9d972108));
    {base_size, base_ident, base_inputs, s} = $urandom;
    addr_sw = 7'($urandom);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(REG_STATUS, 32'h0, "status in boot");
    rchk(REG_CTRL, CTRL_RST, "ctrl reset");
    rchk(REG_INT_EN, 32'h0, "int enable reset");
    base_info_vld <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(REG_STATUS, 32'h11, "status after boot");
    rchk(REG_BASE, {16'h0, base_size, base_ident}, "base info");
    rchk(REG_ADP_ID, 32'h1234, "adapter id");
    chk(bus_fault_indicator, 1'b1, "fault shown before params");
    $display("test boot done");
    rchk(REG_INT_ST, 32'h1, "boot event");
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, REG_INT_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "irq enabled");
    apb(1'b1, REG_INT_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    rchk(REG_INT_ST, 32'h0, "event cleared");
    $display("test irq done");
    base_io_err <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(REG_INT_ST, 32'h8, "io error event");
    chk(irq, 1'b0, "io error masked");
    apb(1'b0, 8'h40, 32'h0);
    chk(ok, 1'b1, "unmapped error");
    apb(1'b1, REG_ADP_ID, 32'hffff);
    rchk(REG_ADP_ID, 32'h1234, "read only id");
    apb(1'b1, REG_SAFE, {24'h0, s});
    rchk(REG_SAFE, {24'h0, s}, "safe readback");
    chk(base_outputs, s, "outputs at shutdown value");
    $display("test regs done");
    i_mst.send_frame({1'b0, addr_sw, FN_CFG, base_ident, base_size});
    i_mst.get_reply(r, ok);
    chk(ok, 1'b1, "reply ended");
    chk(r[17:16], 2'b01, "config accepted");
    chk(r[23], 1'b1, "diag flag in status");
    chk(r[15:0], {base_ident, base_size}, "ident in reply");
    rchk(REG_STATUS, 32'h13, "config ok flag");
    chk(bus_fault_indicator, 1'b1, "fault until params");
    $display("test config done");
    supply_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(base_outputs, s, "outputs safe in supply fault");
    chk(base_params, 8'h00, "params cleared in supply fault");
    supply_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(REG_STATUS, 32'h11, "config dropped");
    $display("test supply done");
    summarize();
  end
endmodule : fba_adapter_test
bind fba_adapter fba_adapter_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_tx(bus_tx), .bus_tx_en(bus_tx_en), .base_info_vld(base_info_vld), .supply_ok(supply_ok));
`default_nettype wire
